// File: logic/rxfc_consts.vh
// constants for the receive flow-control trigger
`ifndef RXFC_CONSTS_VH
`define RXFC_CONSTS_VH
// register byte offsets
`define RXFC_CFG_OFS 12'h000
`define RXFC_STAT_OFS 12'h004
`define RXFC_PAUSE_OFS 12'h008
// configuration field positions
`define RXFC_ANY_BIT 0
`define RXFC_ADDR_BIT 1
`define RXFC_BCAST_BIT 2
`define RXFC_MCAST_BIT 3
`define RXFC_DUR_LSB 4
`define RXFC_DUR_MSB 7
`define RXFC_LO_LSB 8
`define RXFC_LO_MSB 15
`define RXFC_HI_LSB 16
`define RXFC_HI_MSB 23
// reset values
`define RXFC_CFG_RST 32'h0000_0000
`define RXFC_PAUSE_RST 16'h0000
// fill level unit in bytes
`define RXFC_LEVEL_UNIT 64
// duration timing: base steps in ns, 10 Mb/s extra in ns, clock period in ns
`define RXFC_CLK_NS 20
`define RXFC_EXTRA_10M_NS 2200
`define RXFC_STEP_NS 5000
`define RXFC_LONG_STEP_NS 50000
`endif

// File: logic/rxfc_dur_timer.v
// backpressure jam period timer
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_consts.vh"
module rxfc_dur_timer
(
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [3:0] sel_i,
  input wire speed_100_i,
  output wire busy_o
);
  // period lengths in clock cycles, whole cycles (least time rounds up)
  localparam [31:0] STEP_CYC = (`RXFC_STEP_NS + `RXFC_CLK_NS - 1) / `RXFC_CLK_NS;
  localparam [31:0] LSTEP_CYC = (`RXFC_LONG_STEP_NS + `RXFC_CLK_NS - 1) / `RXFC_CLK_NS;
  localparam [31:0] EXTRA_CYC = (`RXFC_EXTRA_10M_NS + `RXFC_CLK_NS - 1) / `RXFC_CLK_NS;
  reg [31:0] cnt_reg;
  reg [31:0] load_next;
  // =====================================================
  // duration decode
  always @*
  begin
    if (sel_i < 4'h3)
      load_next = STEP_CYC * ({28'h0, sel_i} + 32'h1);
    else if (sel_i == 4'h3)
      load_next = STEP_CYC * 32'h5;
    else
      load_next = LSTEP_CYC * ({28'h0, sel_i} - 32'h3);
    if (!speed_100_i)
      load_next = load_next + EXTRA_CYC;
  end
  // =====================================================
  // down counter
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_reg <= 32'h0;
    else if (start_i)
      cnt_reg <= load_next;
    else if (cnt_reg != 32'h0)
      cnt_reg <= cnt_reg - 32'h1;
  end
  assign busy_o = (cnt_reg != 32'h0);
endmodule // rxfc_dur_timer
`default_nettype wire

// File: logic/rxfc_trigger.v
// receive fifo automatic flow-control trigger with apb registers
//
// Summary of operation
// - any-frame bit set: any received frame past threshold triggers flow control
// - full-duplex auto flow control only with any-frame bit and full duplex
// - half duplex any-frame: react at valid preamble, no address decode
// - full duplex any-frame: request pause as fifo reaches high threshold
// - pause request stays pending until transmitter takes it
// - any-frame bit overrides multicast, broadcast, address-match selections
// - duration code maps to 5..600 us; 10 Mb/s adds 2.2 us
// - high threshold compared to fifo fill in 64-byte units
// - one pause frame with programmed time per high-threshold crossing
// - zero-time pause below low threshold only after a pause was sent
// - backpressure lasts the selected period; unused in full duplex
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_consts.vh"
module rxfc_trigger
#(
  parameter FILL_W = 14
)
(
  input wire ref_clk_i,
  input wire rst_n_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // mac side, same clock
  input wire [FILL_W-1:0] rx_fill_bytes_i,
  input wire full_duplex_i,
  input wire speed_100_i,
  input wire rx_preamble_i,
  input wire rx_frame_start_i,
  input wire rx_multicast_i,
  input wire rx_broadcast_i,
  input wire rx_addr_match_i,
  input wire pause_ack_i,
  output reg pause_req_o,
  output reg [15:0] pause_time_o,
  output reg backpressure_o
);
  reg [31:0] cfg_reg;
  reg [15:0] pause_time_value_reg;
  reg paused_reg;
  reg pend_reg;
  reg pend_zero_reg;
  reg jam_count_start_reg;
  reg [15:0] jam_events_reg;
  wire any_frame_flow_trigger = cfg_reg[`RXFC_ANY_BIT];
  wire address_match_flow_trigger = cfg_reg[`RXFC_ADDR_BIT];
  wire broadcast_flow_trigger = cfg_reg[`RXFC_BCAST_BIT];
  wire multicast_flow_trigger = cfg_reg[`RXFC_MCAST_BIT];
  wire [3:0] backpressure_period_select = cfg_reg[`RXFC_DUR_MSB:`RXFC_DUR_LSB];
  wire [7:0] flow_low_threshold = cfg_reg[`RXFC_LO_MSB:`RXFC_LO_LSB];
  wire [7:0] flow_high_threshold = cfg_reg[`RXFC_HI_MSB:`RXFC_HI_LSB];
  // =====================================================
  // fill level in 64-byte units
  // unit held at the fill width so the quotient keeps that width
  localparam [FILL_W-1:0] LEVEL_UNIT = `RXFC_LEVEL_UNIT;
  wire [FILL_W-1:0] fill_units = rx_fill_bytes_i / LEVEL_UNIT;
  wire [FILL_W+7:0] fill_wide = {8'h0, fill_units};
  wire at_high = fill_wide >= {{FILL_W{1'b0}}, flow_high_threshold};
  wire below_low = fill_wide < {{FILL_W{1'b0}}, flow_low_threshold};
  // =====================================================
  // half-duplex frame qualification
  wire sel_match = (multicast_flow_trigger && rx_multicast_i) ||
                   (broadcast_flow_trigger && rx_broadcast_i) ||
                   (address_match_flow_trigger && rx_addr_match_i);
  wire hd_hit = any_frame_flow_trigger ? rx_preamble_i :
                (rx_frame_start_i && sel_match);
  wire jam_start = !full_duplex_i && at_high && hd_hit && !backpressure_o;
  wire jam_busy;
  // full duplex active only with any-frame bit
  wire fd_en = any_frame_flow_trigger && full_duplex_i;
  wire fd_pause = fd_en && at_high && !paused_reg && !pend_reg;
  wire fd_resume = fd_en && below_low && paused_reg && !pend_reg;
  // =====================================================
  // jam period timer
  rxfc_dur_timer u_timer
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(jam_start),
    .sel_i(backpressure_period_select),
    .speed_100_i(speed_100_i),
    .busy_o(jam_busy)
  );
  // =====================================================
  // apb access decode
  wire apb_wr = psel_i && penable_i && pwrite_i;
  wire apb_rd = psel_i && !pwrite_i;
  wire addr_ok = (paddr_i == `RXFC_CFG_OFS) || (paddr_i == `RXFC_STAT_OFS) ||
                 (paddr_i == `RXFC_PAUSE_OFS);
  // configuration and pause time registers
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_reg <= `RXFC_CFG_RST;
      pause_time_value_reg <= `RXFC_PAUSE_RST;
    end
    else if (apb_wr && pready_o)
    begin
      if (paddr_i == `RXFC_CFG_OFS)
        cfg_reg <= {8'h00, pwdata_i[23:0]};
      if (paddr_i == `RXFC_PAUSE_OFS)
        pause_time_value_reg <= pwdata_i[15:0];
    end
  end
  // one wait state: pready high in second access cycle
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end
    else
    begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !addr_ok;
      if (apb_rd && !pready_o)
      begin
        case (paddr_i)
          `RXFC_CFG_OFS: prdata_o <= cfg_reg;
          `RXFC_STAT_OFS: prdata_o <= {jam_events_reg, 11'h0, at_high, paused_reg,
                                       pend_reg, pause_req_o, backpressure_o};
          `RXFC_PAUSE_OFS: prdata_o <= {16'h0, pause_time_value_reg};
          default: prdata_o <= 32'h0;
        endcase
      end
    end
  end
  // =====================================================
  // pause request handshake with mac transmitter
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pend_reg <= 1'b0;
      pend_zero_reg <= 1'b0;
      paused_reg <= 1'b0;
      pause_req_o <= 1'b0;
      pause_time_o <= 16'h0;
    end
    else
    begin
      if (pend_reg && pause_ack_i)
      begin
        pend_reg <= 1'b0;
        pause_req_o <= 1'b0;
        paused_reg <= !pend_zero_reg;
      end
      else if (fd_pause)
      begin
        pend_reg <= 1'b1;
        pend_zero_reg <= 1'b0;
        pause_req_o <= 1'b1;
        pause_time_o <= pause_time_value_reg;
      end
      else if (fd_resume)
      begin
        pend_reg <= 1'b1;
        pend_zero_reg <= 1'b1;
        pause_req_o <= 1'b1;
        pause_time_o <= 16'h0;
      end
      else if (!fd_en && !pend_reg)
        paused_reg <= 1'b0;
    end
  end
  // =====================================================
  // backpressure output and event count
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      backpressure_o <= 1'b0;
      jam_count_start_reg <= 1'b0;
      jam_events_reg <= 16'h0;
    end
    else
    begin
      jam_count_start_reg <= jam_start;
      backpressure_o <= jam_start || (jam_busy && !full_duplex_i);
      if (jam_count_start_reg)
        jam_events_reg <= jam_events_reg + 16'h1;
    end
  end
endmodule // rxfc_trigger
`default_nettype wire

// File: sim/rxfc_mac_model.sv
// transmitter partner model that takes pending pause frames
`timescale 1ns/1ps
`default_nettype none
module rxfc_mac_model
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [7:0] dly_i,
  output logic ack_o
);
  logic [7:0] wait_reg;
  // take the pending pause after dly_i cycles, one ack per request
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      {wait_reg, ack_o} <= 9'h000;
    else
    begin
      ack_o <= req_i && !ack_o && wait_reg == dly_i;
      wait_reg <= (req_i && !ack_o && wait_reg != dly_i) ? wait_reg + 8'h01 : 8'h00;
    end
  end
endmodule // rxfc_mac_model
`default_nettype wire

// File: sim/rxfc_trigger_sva.sv
// assertions on the flow-control trigger ports
`timescale 1ns/1ps
`default_nettype none
module rxfc_trigger_sva
(
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire full_duplex_i,
  input wire rx_preamble_i,
  input wire rx_frame_start_i,
  input wire pause_ack_i,
  input wire pause_req_o,
  input wire [15:0] pause_time_o,
  input wire backpressure_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // bus handshake and flow-control outputs
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_ready_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready after one wait");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_req_hold: assert property (pause_req_o && !pause_ack_i |=> pause_req_o && $stable(pause_time_o))
    else $error("pause request dropped");
  a_req_clear: assert property (pause_req_o && pause_ack_i |=> !pause_req_o)
    else $error("pause request not cleared");
  a_req_duplex: assert property ($rose(pause_req_o) |-> $past(full_duplex_i))
    else $error("pause outside full duplex");
  a_jam_cause: assert property ($rose(backpressure_o) |-> $past(rx_preamble_i || rx_frame_start_i))
    else $error("jam without frame");
  a_jam_duplex: assert property (full_duplex_i [*2] |-> !backpressure_o)
    else $error("jam in full duplex");
  a_jam_holds: assert property ($rose(backpressure_o) |-> backpressure_o [*8])
    else $error("jam too short");
  c_jam: cover property ($rose(backpressure_o));
  c_pause: cover property (pause_req_o && pause_ack_i);
  c_err: cover property (pslverr_o);
endmodule // rxfc_trigger_sva
bind rxfc_trigger rxfc_trigger_sva u_sva(.ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pready_o,
  .pslverr_o, .full_duplex_i, .rx_preamble_i, .rx_frame_start_i, .pause_ack_i, .pause_req_o,
  .pause_time_o, .backpressure_o);
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the flow-control trigger
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_consts.vh"
module testbench;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, fd = 0, spd = 1, pre = 0, fs = 0, am = 0;
  logic pready, pslverr, preq, bp, ack, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [13:0] fill = 0;
  logic [15:0] ptime;
  logic [7:0] dly = 0;
  int n_fail = 0, num_checks = 0, n;
  // rows: duration code, 100 Mb/s, jam cycles
  logic [19:0] rows [7] = '{{4'h0, 1'b1, 15'd250}, {4'h1, 1'b1, 15'd500}, {4'h2, 1'b1, 15'd750},
    {4'h3, 1'b1, 15'd1250}, {4'h0, 1'b0, 15'd360}, {4'h4, 1'b0, 15'd2610}, {4'hf, 1'b1, 15'd30000}};
  initial forever #10 clk = ~clk;
  rxfc_trigger u_dut(.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_fill_bytes_i(fill), .full_duplex_i(fd), .speed_100_i(spd),
    .rx_preamble_i(pre), .rx_frame_start_i(fs), .rx_multicast_i(1'b0), .rx_broadcast_i(1'b0),
    .rx_addr_match_i(am), .pause_ack_i(ack), .pause_req_o(preq), .pause_time_o(ptime),
    .backpressure_o(bp));
  rxfc_mac_model u_mac(.ref_clk_i(clk), .rst_n_i(rst_n), .req_i(preq), .dly_i(dly), .ack_o(ack));
  // ==========================================
  // tasks
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for ready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++i < 20);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1)
      chk(0, 1);
    if (pready !== 1'b1)
      conclude();
    {psel, pen} <= 2'b00;
  endtask
  // pulse preamble, frame start, match; count jam cycles, one extra allowed when a jam is due
  task hit(input logic [2:0] s, input int exp);
    {pre, fs, am} <= s;
    @(posedge clk);
    {pre, fs, am} <= 3'b000;
    n = 0;
    repeat (exp + 40) @(posedge clk) n += (bp === 1'b1);
    chk((n - exp) >> (exp > 0), 0);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `RXFC_CFG_OFS, 0);
    chk(rd, 0);
    apb(1'b0, 12'h0fc, 0);
    chk({rd[30:0], err}, 1);
    fill <= 14'd64;
    foreach (rows[k])
    begin
      spd <= rows[k][15];
      apb(1'b1, `RXFC_CFG_OFS, {16'h0001, rows[k][19:16], 4'hf});
      hit(3'b100, rows[k][14:0]);
    end
    apb(1'b1, `RXFC_CFG_OFS, 32'h0001_0002);
    apb(1'b0, `RXFC_CFG_OFS, 0);
    chk(rd, 32'h0001_0002);
    hit(3'b100, 0);
    hit(3'b010, 0);
    hit(3'b011, 250);
    fill <= 14'd63;
    hit(3'b011, 0);
    fd <= 1'b1;
    dly <= 8'd20;
    fill <= 14'd0;
    apb(1'b1, `RXFC_PAUSE_OFS, 32'h1234);
    apb(1'b0, `RXFC_PAUSE_OFS, 0);
    chk(rd, 32'h1234);
    apb(1'b1, `RXFC_CFG_OFS, 32'h0002_0101);
    fill <= 14'd128;
    repeat (2) @(posedge clk);
    chk({preq, ptime}, 17'h11234);
    repeat (60) @(posedge clk);
    chk(preq, 0);
    dly <= 8'd0;
    fill <= 14'd0;
    repeat (2) @(posedge clk);
    chk({preq, ptime}, 17'h10000);
    apb(1'b1, `RXFC_CFG_OFS, 32'h0002_0102);
    fill <= 14'd128;
    repeat (10) @(posedge clk);
    chk(preq, 0);
    apb(1'b0, `RXFC_STAT_OFS, 0);
    chk(rd, 32'h0008_0010);
    // mid-run reset clears the configuration again
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `RXFC_CFG_OFS, 0);
    chk(rd, 0);
    chk({preq, bp}, 0);
    conclude();
  end
endmodule // testbench
`default_nettype wire
